// ==== hdl/dpc_top.sv ====
// DMA channel primary control: AHB-Lite slave, per-channel registers, irq
//
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module dpc_top #(
  parameter int NCH  = 4,
  parameter int NEXT = 14
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             nrst_in,
  // AHB-Lite slave
  input  wire logic             hsel_in,
  input  wire logic [31:0]      haddr_in,
  input  wire logic [1:0]       htrans_in,
  input  wire logic             hwrite_in,
  input  wire logic [2:0]       hsize_in,
  input  wire logic [31:0]      hwdata_in,
  input  wire logic             hready_in,
  output logic                  hreadyout_out,
  output logic [31:0]           hrdata_out,
  output logic                  hresp_out,
  // Engine and emulation inputs
  input  wire logic             emu_halt_in,
  input  wire logic [NCH-1:0]   block_done_in,
  input  wire logic [NEXT-1:0]  sync_events_in,
  // Per-channel run control
  output logic [NCH-1:0]        run_out,
  output logic [NCH-1:0]        autoinit_out,
  output logic [NCH-1:0]        frame_start_out,
  output logic [NCH-1:0]        read_sync_evt_out,
  output logic [NCH-1:0]        write_sync_evt_out,
  output logic [NCH-1:0]        sync_reserved_out,
  // Per-channel decoded fields
  output logic [2*NCH-1:0]      dest_reload_sel_out,
  output logic [2*NCH-1:0]      src_reload_sel_out,
  output logic [NCH-1:0]        dest_reload_en_out,
  output logic [NCH-1:0]        src_reload_en_out,
  output logic [NCH-1:0]        frame_sync_enable_out,
  output logic [NCH-1:0]        dma_priority_out,
  output logic [NCH-1:0]        index_sel_out,
  output logic [NCH-1:0]        count_reload_sel_out,
  output logic [NCH-1:0]        split_enable_out,
  output logic [2*NCH-1:0]      split_sel_out,
  output logic [2*NCH-1:0]      element_size_out,
  output logic [2*NCH-1:0]      dest_address_step_out,
  output logic [2*NCH-1:0]      source_address_step_out,
  // Interrupt
  output logic                  irq_out
);

  // Address phase capture
  logic             dp_wr_r;      // Data phase is a write
  logic             dp_rd_r;      // Data phase is a read
  logic [7:0]       dp_addr_r;    // Captured byte offset
  logic             addr_ok;      // Valid transfer this cycle

  // Interrupt registers
  logic [NCH-1:0]   irq_stat_r;   // Sticky completion flags
  logic [NCH-1:0]   irq_mask_r;   // One enables a flag onto irq_out
  logic [NCH-1:0]   irq_stat_nxt;

  // Decoded data phase selects
  logic [NCH-1:0]   ch_sel;       // Channel register hit
  logic             stat_sel;
  logic             mask_sel;

  // Event table size must be known before the vector is declared
  localparam int NUM_LOCAL = dpc_pkg::NUM_EVT;

  // Per-channel wiring
  logic [31:0]      ch_ctrl [NCH];
  logic [NCH-1:0]   ch_done_evt;  // Completion with irq enabled
  logic [NUM_LOCAL-1:0] evt_vec;  // Full event table, bit c-1 is code c
  logic [31:0]      rd_mux;

  // Channel events fill codes 8h-Bh; outside events fill the rest
  assign evt_vec = {sync_events_in[NEXT-1:dpc_pkg::CH_EVT_LO],
                    ch_done_evt,
                    sync_events_in[dpc_pkg::CH_EVT_LO-1:0]};

  // Zero wait states and always OKAY keep the slave trivially legal
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign addr_ok = hsel_in & hready_in &
                   (htrans_in == dpc_pkg::HTRANS_NONSEQ ||
                    htrans_in == dpc_pkg::HTRANS_SEQ);

  // Address phase register; only whole-word accesses write
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      dp_wr_r   <= 1'b0;
      dp_rd_r   <= 1'b0;
      dp_addr_r <= 8'h00;
    end else begin
      dp_wr_r   <= addr_ok & hwrite_in & (hsize_in == 3'h2);
      dp_rd_r   <= addr_ok & ~hwrite_in;
      dp_addr_r <= {haddr_in[7:2], 2'h0};
    end
  end

  assign stat_sel = dp_addr_r == dpc_pkg::ADDR_IRQ_STAT;
  assign mask_sel = dp_addr_r == dpc_pkg::ADDR_IRQ_MASK;

  // One register instance per channel, with its own sync decoders
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic [31:0] f;
      logic        rd_evt;
      assign ch_sel[g] = dp_addr_r == dpc_pkg::ADDR_CH0 +
                         8'(g) * dpc_pkg::ADDR_STRIDE;

      dpc_chan_ctrl u_chan (
        .clk_in        (clk_in),
        .nrst_in       (nrst_in),
        .wr_in         (dp_wr_r & ch_sel[g]),
        .wdata_in      (hwdata_in),
        .emu_halt_in   (emu_halt_in),
        .block_done_in (block_done_in[g]),
        .ctrl_out      (ch_ctrl[g]),
        .run_out       (run_out[g]),
        .autoinit_out  (autoinit_out[g]),
        .done_evt_out  (ch_done_evt[g])
      );
      assign f = ch_ctrl[g];

      dpc_sync_decode u_read_sync_select (
        .clk_in       (clk_in),
        .nrst_in      (nrst_in),
        .sel_in       (f[dpc_pkg::READ_SYNC_SELECT_LSB +: 5]),
        .events_in    (evt_vec),
        .evt_out      (rd_evt),
        .reserved_out ()
      );
      dpc_sync_decode u_write_sync_select (
        .clk_in       (clk_in),
        .nrst_in      (nrst_in),
        .sel_in       (f[dpc_pkg::WRITE_SYNC_SELECT_LSB +: 5]),
        .events_in    (evt_vec),
        .evt_out      (write_sync_evt_out[g]),
        .reserved_out (sync_reserved_out[g])
      );

      // Read event either paces elements or launches a whole frame
      assign read_sync_evt_out[g] = rd_evt;
      assign frame_start_out[g]   = rd_evt & run_out[g] &
                                    f[dpc_pkg::FSYNC_BIT];
      assign frame_sync_enable_out[g] = f[dpc_pkg::FSYNC_BIT];

      // Reload selectors: code 1-3 means register B-D, 0 means none
      assign dest_reload_sel_out[2*g +: 2] = f[dpc_pkg::DST_RLD_LSB +: 2];
      assign src_reload_sel_out[2*g +: 2]  = f[dpc_pkg::SRC_RLD_LSB +: 2];
      assign dest_reload_en_out[g] = |f[dpc_pkg::DST_RLD_LSB +: 2];
      assign src_reload_en_out[g]  = |f[dpc_pkg::SRC_RLD_LSB +: 2];

      assign dma_priority_out[g]     = f[dpc_pkg::PRIO_BIT];
      assign index_sel_out[g]        = f[dpc_pkg::INDEX_BIT];
      assign count_reload_sel_out[g] = f[dpc_pkg::CNT_RLD_BIT];

      // Split: code 1-3 picks register A-C as split address
      assign split_sel_out[2*g +: 2] = f[dpc_pkg::SPLIT_LSB +: 2];
      assign split_enable_out[g]     = |f[dpc_pkg::SPLIT_LSB +: 2];

      // Step codes: 0 hold, 1 increment, 2 decrement, 3 use index
      assign element_size_out[2*g +: 2]      = f[dpc_pkg::ELEMENT_SIZE_LSB +: 2];
      assign dest_address_step_out[2*g +: 2] = f[dpc_pkg::DSTEP_LSB +: 2];
      assign source_address_step_out[2*g +: 2] =
        f[dpc_pkg::SSTEP_LSB +: 2];
    end
  endgenerate

  // Sticky flags: a new event wins over the clear-on-read
  assign irq_stat_nxt = ((dp_rd_r & stat_sel) ? '0 : irq_stat_r) |
                        ch_done_evt;

  // Interrupt status and mask registers
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      if (dp_wr_r && mask_sel) begin
        irq_mask_r <= hwdata_in[NCH-1:0];
      end
    end
  end

  assign irq_out = |(irq_stat_r & irq_mask_r);

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    for (int i = 0; i < NCH; i++) begin
      if (ch_sel[i]) begin
        rd_mux = ch_ctrl[i];
      end
    end
    if (stat_sel) begin
      rd_mux = 32'(irq_stat_r);
    end
    if (mask_sel) begin
      rd_mux = 32'(irq_mask_r);
    end
  end

  assign hrdata_out = dp_rd_r ? rd_mux : 32'h0000_0000;

  property p_reset_zero;
    @(posedge clk_in)
    !nrst_in |=> ch_ctrl[0] == 32'h0 && ch_ctrl[NCH-1] == 32'h0 && !irq_out;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("Register not zero after reset");

  property p_status_ro;
    @(posedge clk_in) disable iff (!nrst_in)
    dp_wr_r && ch_sel[0] && hwdata_in[1:0] == 2'h0 |=> ch_ctrl[0][3:2] == 2'h0;
  endproperty
  a_status_ro: assert property (p_status_ro)
    else $error("Written status bits leaked into status");

  property p_irq_flag;
    @(posedge clk_in) disable iff (!nrst_in)
    ch_done_evt[0] && irq_mask_r[0] && !(dp_wr_r && mask_sel) |=> irq_out;
  endproperty
  a_irq_flag: assert property (p_irq_flag)
    else $error("Enabled completion raised no interrupt");

  property p_prio_bit;
    @(posedge clk_in) disable iff (!nrst_in)
    dp_wr_r && ch_sel[0] |=> dma_priority_out[0] == $past(hwdata_in[24]);
  endproperty
  a_prio_bit: assert property (p_prio_bit)
    else $error("Priority bit not stored");

  property p_frame_gate;
    @(posedge clk_in) disable iff (!nrst_in)
    frame_start_out[0] |-> frame_sync_enable_out[0] && run_out[0];
  endproperty
  a_frame_gate: assert property (p_frame_gate)
    else $error("Frame start without frame sync");

endmodule : dpc_top
`default_nettype wire

// ==== hdl/dpc_pkg.sv ====
// Constants, field layout and codes of the DMA channel primary control block
package dpc_pkg;

  // Field positions inside the channel register
  localparam int DST_RLD_LSB  = 30;
  localparam int SRC_RLD_LSB  = 28;
  localparam int EMU_BIT      = 27;
  localparam int FSYNC_BIT    = 26;
  localparam int IRQ_EN_BIT   = 25;
  localparam int PRIO_BIT     = 24;
  localparam int WRITE_SYNC_SELECT_LSB    = 19;
  localparam int READ_SYNC_SELECT_LSB    = 14;
  localparam int INDEX_BIT    = 13;
  localparam int CNT_RLD_BIT  = 12;
  localparam int SPLIT_LSB    = 10;
  localparam int ELEMENT_SIZE_LSB    = 8;
  localparam int DSTEP_LSB    = 6;
  localparam int SSTEP_LSB    = 4;
  localparam int STATUS_LSB   = 2;
  localparam int CMD_LSB      = 0;

  // Reset value and writable bits (status bits 3:2 excluded)
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK = 32'hffff_fff3;

  // Byte offsets on the register bus
  localparam logic [7:0] ADDR_CH0      = 8'h00;
  localparam logic [7:0] ADDR_STRIDE   = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

  // Sync selector codes
  localparam logic [4:0] SYNC_NONE = 5'h00;
  localparam logic [4:0] SYNC_LAST = 5'h12;
  localparam int         NUM_EVT   = 18;
  localparam int         CH_EVT_LO = 7;   // Code 8h sits at vector bit 7

  // Bus transfer kinds
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;

  // Command written by software
  typedef enum logic [1:0] {
    CMD_STOP   = 2'h0,
    CMD_NORMAL = 2'h1,
    CMD_PAUSE  = 2'h2,
    CMD_AUTO   = 2'h3
  } dpc_cmd_t;

  // Channel state, also the reported status code
  typedef enum logic [1:0] {
    ST_STOPPED = 2'h0,
    ST_RUNNING = 2'h1,
    ST_PAUSED  = 2'h2,
    ST_AUTORUN = 2'h3
  } dpc_state_t;

endpackage : dpc_pkg

// ==== hdl/dpc_sync_decode.sv ====
// Sync selector decoder: picks one event line by its 5-bit code
`timescale 1ns/1ps
`default_nettype none
module dpc_sync_decode #(
  parameter int NEVT = dpc_pkg::NUM_EVT
) (
  // Clock and reset, used by the checks only
  input  wire logic            clk_in,
  input  wire logic            nrst_in,
  // Selector and event lines, bit c-1 is code c
  input  wire logic [4:0]      sel_in,
  input  wire logic [NEVT-1:0] events_in,
  // Selected event pulse and reserved-code flag
  output logic                 evt_out,
  output logic                 reserved_out
);

  logic [NEVT-1:0] hit;  // One-hot match per code

  // Code 0 matches nothing, codes past the table match nothing
  genvar c;
  generate
    for (c = 1; c <= NEVT; c++) begin : g_code
      assign hit[c-1] = (sel_in == 5'(c)) & events_in[c-1];
    end
  endgenerate

  assign evt_out      = |hit;
  assign reserved_out = sel_in > dpc_pkg::SYNC_LAST;

  property p_no_sync;
    @(posedge clk_in) disable iff (!nrst_in)
    sel_in == dpc_pkg::SYNC_NONE |-> !evt_out;
  endproperty
  a_no_sync: assert property (p_no_sync)
    else $error("Code zero selected an event");

  property p_reserved_quiet;
    @(posedge clk_in) disable iff (!nrst_in)
    reserved_out |-> !evt_out && sel_in >= 5'h13;
  endproperty
  a_reserved_quiet: assert property (p_reserved_quiet)
    else $error("Reserved code selected an event");

endmodule : dpc_sync_decode
`default_nettype wire

// ==== hdl/dpc_chan_ctrl.sv ====
// One channel's control register and run state machine
`timescale 1ns/1ps
`default_nettype none
module dpc_chan_ctrl (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  // Register write port
  input  wire logic        wr_in,
  input  wire logic [31:0] wdata_in,
  // Engine side
  input  wire logic        emu_halt_in,
  input  wire logic        block_done_in,
  // Readback and run control
  output logic [31:0]      ctrl_out,
  output logic             run_out,
  output logic             autoinit_out,
  output logic             done_evt_out
);

  logic [31:0]        cfg_r;      // Writable fields
  dpc_pkg::dpc_state_t state_r;   // Run state
  dpc_pkg::dpc_state_t state_nxt;
  dpc_pkg::dpc_state_t shown;     // Status as software sees it
  logic               active;    // Running in either mode
  logic               emu_hold;  // Held by an emulation halt
  logic [1:0]         cmd;       // Command in the write data

  assign cmd      = wdata_in[dpc_pkg::CMD_LSB +: 2];
  assign active   = state_r == dpc_pkg::ST_RUNNING ||
                    state_r == dpc_pkg::ST_AUTORUN;
  assign emu_hold = active & emu_halt_in & cfg_r[dpc_pkg::EMU_BIT];

  // Next state: a write command outranks a completing block
  always_comb begin
    state_nxt = state_r;
    if (wr_in) begin
      case (cmd)
        dpc_pkg::CMD_STOP:   state_nxt = dpc_pkg::ST_STOPPED;
        dpc_pkg::CMD_NORMAL: state_nxt = dpc_pkg::ST_RUNNING;
        dpc_pkg::CMD_PAUSE:  state_nxt = dpc_pkg::ST_PAUSED;
        dpc_pkg::CMD_AUTO:   state_nxt = dpc_pkg::ST_AUTORUN;
        default:             state_nxt = state_r;
      endcase
    end else if (block_done_in && state_r == dpc_pkg::ST_RUNNING) begin
      state_nxt = dpc_pkg::ST_STOPPED;
    end
  end

  // Registers; status bits are masked so writes cannot reach them
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      cfg_r   <= dpc_pkg::CTRL_RESET;
      state_r <= dpc_pkg::ST_STOPPED;
    end else begin
      if (wr_in) begin
        cfg_r <= wdata_in & dpc_pkg::CTRL_WMASK;
      end
      state_r <= state_nxt;
    end
  end

  // A channel held by emulation reports paused
  assign shown        = emu_hold ? dpc_pkg::ST_PAUSED : state_r;
  assign ctrl_out     = {cfg_r[31:4], 2'(shown), cfg_r[1:0]};
  assign run_out      = active & ~emu_hold;
  assign autoinit_out = state_r == dpc_pkg::ST_AUTORUN;
  assign done_evt_out = block_done_in & active &
                        cfg_r[dpc_pkg::IRQ_EN_BIT];

  property p_cmd_stop;
    @(posedge clk_in) disable iff (!nrst_in)
    wr_in && cmd == dpc_pkg::CMD_STOP |=> ctrl_out[3:2] == 2'h0 && !run_out;
  endproperty
  a_cmd_stop: assert property (p_cmd_stop)
    else $error("Stop command did not stop the channel");

  property p_cmd_pause;
    @(posedge clk_in) disable iff (!nrst_in)
    wr_in && cmd == dpc_pkg::CMD_PAUSE |=> state_r == dpc_pkg::ST_PAUSED;
  endproperty
  a_cmd_pause: assert property (p_cmd_pause)
    else $error("Pause command did not pause");

  property p_status_hold;
    @(posedge clk_in) disable iff (!nrst_in)
    !wr_in && !block_done_in |=> state_r == $past(state_r);
  endproperty
  a_status_hold: assert property (p_status_hold)
    else $error("Status changed without a cause");

  sequence s_normal_done;
    state_r == dpc_pkg::ST_RUNNING && block_done_in && !wr_in;
  endsequence
  property p_normal_done;
    @(posedge clk_in) disable iff (!nrst_in)
    s_normal_done |=> state_r == dpc_pkg::ST_STOPPED ##1
                      state_r == dpc_pkg::ST_STOPPED || $past(wr_in);
  endproperty
  a_normal_done: assert property (p_normal_done)
    else $error("Finished block left channel running");

  property p_auto_keeps;
    @(posedge clk_in) disable iff (!nrst_in)
    state_r == dpc_pkg::ST_AUTORUN && block_done_in && !wr_in
      |=> autoinit_out;
  endproperty
  a_auto_keeps: assert property (p_auto_keeps)
    else $error("Autoinit channel stopped at block end");

  property p_emu_pause;
    @(posedge clk_in) disable iff (!nrst_in)
    active && emu_halt_in && cfg_r[dpc_pkg::EMU_BIT]
      |-> !run_out && ctrl_out[3:2] == 2'h2;
  endproperty
  a_emu_pause: assert property (p_emu_pause)
    else $error("Channel ran during emulation halt");

  property p_emu_free;
    @(posedge clk_in) disable iff (!nrst_in)
    active && !cfg_r[dpc_pkg::EMU_BIT] |-> run_out;
  endproperty
  a_emu_free: assert property (p_emu_free)
    else $error("Channel stalled with emulation pause off");

endmodule : dpc_chan_ctrl
`default_nettype wire

// ==== test/dpc_top_tb.sv ====
// Self-checking bench for the DMA channel primary control block
`timescale 1ns/1ps
`default_nettype none
module dpc_top_tb;
  // Clock, reset and bus drive
  logic        clk_in         = 1'b0;
  logic        nrst_in        = 1'b0;
  logic        hsel_in        = 1'b0;
  logic [31:0] haddr_in       = 32'h0;
  logic [1:0]  htrans_in      = 2'h0;
  logic        hwrite_in      = 1'b0;
  logic [2:0]  hsize_in       = 3'h2;
  logic [31:0] hwdata_in      = 32'h0;
  // Engine side drive
  logic        emu_halt_in    = 1'b0;
  logic [3:0]  block_done_in  = 4'h0;
  logic [13:0] sync_events_in = 14'h0;
  // Design outputs
  wire logic        hrdy, hresp, irq;
  wire logic [31:0] hrdata;
  wire logic [3:0]  run, ainit, fst, rse, wse, rsv, den, sen;
  wire logic [3:0]  fse, priority_select, idx, crl, spe;
  wire logic [7:0]  dsel, ssel, spl, esz, dst, sst;
  // Model state and score
  logic [31:0] m_ctrl [4];      // Channel registers, status bits included
  logic [3:0]  m_stat, m_mask;  // Interrupt status and mask
  logic [31:0] q;               // Last read data
  int          err_total    = 0;
  int          total_checks = 0;

  dpc_top #(.NCH(4), .NEXT(14)) u_dut (
    .clk_in(clk_in), .nrst_in(nrst_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
    .hsize_in(hsize_in), .hwdata_in(hwdata_in), .hready_in(hrdy),
    .hreadyout_out(hrdy), .hrdata_out(hrdata), .hresp_out(hresp),
    .emu_halt_in(emu_halt_in), .block_done_in(block_done_in),
    .sync_events_in(sync_events_in), .run_out(run),
    .autoinit_out(ainit), .frame_start_out(fst),
    .read_sync_evt_out(rse), .write_sync_evt_out(wse),
    .sync_reserved_out(rsv), .dest_reload_sel_out(dsel),
    .src_reload_sel_out(ssel), .dest_reload_en_out(den),
    .src_reload_en_out(sen), .frame_sync_enable_out(fse),
    .dma_priority_out(priority_select), .index_sel_out(idx),
    .count_reload_sel_out(crl), .split_enable_out(spe),
    .split_sel_out(spl), .element_size_out(esz),
    .dest_address_step_out(dst), .source_address_step_out(sst),
    .irq_out(irq));

  // Free-running 200 MHz clock
  always #2.5 clk_in = ~clk_in;

  // Ends the run with the verdict
  task automatic close_out();
    $display("Checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  // Compare read data with the model
  task automatic chk_rd(input string nm, input logic [31:0] e);
    total_checks++;
    if (q !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, q);
    end
  endtask : chk_rd

  // Compare port values with the model
  task automatic chk_pin(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_pin

  // One single transfer of size sz; hsel stays high so it never toggles twice
  task automatic bus(input logic w, input logic [31:0] a, d,
                     input logic [2:0] sz);
    hsel_in   <= 1'b1;
    htrans_in <= dpc_pkg::HTRANS_NONSEQ;
    haddr_in  <= a;
    hwrite_in <= w;
    hsize_in  <= sz;
    do @(posedge clk_in); while (hrdy !== 1'b1);
    htrans_in <= 2'h0;
    hwdata_in <= d;
    do @(posedge clk_in); while (hrdy !== 1'b1);
    q = hrdata;
  endtask : bus

  // Word write at index n, mirrored into the model
  task automatic wr(input int n, input logic [31:0] d);
    bus(1'b1, 32'(4 * n), d, 3'h2);
    if (n < 4)
      m_ctrl[n] = (d & dpc_pkg::CTRL_WMASK) | {28'h0, d[1:0], 2'h0};
    else if (n == 5)
      m_mask = d[3:0];
  endtask : wr

  // Value the model expects on a read of index n
  function automatic logic [31:0] exp_rd(input int n);
    logic [31:0] v;
    v = 32'h0;
    if (n < 4) begin
      v = m_ctrl[n];
      // Emulation hold shows paused without touching the stored state
      if (emu_halt_in && v[27] && v[2]) v[3:2] = 2'h2;
    end else if (n == 4) v = {28'h0, m_stat};
    else if (n == 5) v = {28'h0, m_mask};
    return v;
  endfunction : exp_rd

  // Word read at index n; the status read clears the model's copy
  task automatic rd(input int n);
    bus(1'b0, 32'(4 * n), 32'h0, 3'h2);
    chk_rd("register read", exp_rd(n));
    chk_pin("bus response", 32'h0, {31'h0, hresp});
    if (n == 4) m_stat = 4'h0;
  endtask : rd

  // Decoded fields of channel n, sampled mid-cycle
  task automatic fld(input int n);
    logic [31:0] v;
    logic [1:0]  s;
    @(negedge clk_in);
    v = m_ctrl[n];
    s = 2'(exp_rd(n) >> 2);
    chk_pin("fields", {10'h0, v[31:28], |v[31:30], |v[29:28], v[26], v[24],
      v[13:12], |v[11:10], v[11:4], v[23:19] > 5'h12, v[3:2] == 2'h3,
      s[0]}, {10'h0, dsel[2*n+:2], ssel[2*n+:2], den[n], sen[n], fse[n],
      priority_select[n], idx[n], crl[n], spe[n], spl[2*n+:2], esz[2*n+:2],
      dst[2*n+:2], sst[2*n+:2], rsv[n], ainit[n], run[n]});
    @(posedge clk_in);
  endtask : fld

  // Event selected by a sync code; ce holds channel completion events
  function automatic logic evx(input logic [4:0] c, input logic [13:0] ev,
                               input logic [3:0] ce);
    if (c >= 5'h1 && c <= 5'h7) return ev[c - 5'h1];
    if (c >= 5'h8 && c <= 5'hb) return ce[c - 5'h8];
    if (c >= 5'hc && c <= 5'h12) return ev[c - 5'h5];
    return 1'b0;
  endfunction : evx

  // One-cycle pulse on events and done lines; outputs gathered over
  // two cycles so either a direct or a registered pulse is accepted
  task automatic pulse(input logic [13:0] ev, input logic [3:0] dn);
    int          i;
    logic [31:0] v;
    logic [3:0]  ce, er, ew, ef, ar, aw, af;
    sync_events_in <= ev;
    block_done_in  <= dn;
    @(negedge clk_in);
    ar = rse;
    aw = wse;
    af = fst;
    @(posedge clk_in);
    sync_events_in <= 14'h0;
    block_done_in  <= 4'h0;
    @(negedge clk_in);
    ar |= rse;
    aw |= wse;
    af |= fst;
    @(posedge clk_in);
    for (i = 0; i < 4; i++) ce[i] = dn[i] & m_ctrl[i][25] & m_ctrl[i][2];
    for (i = 0; i < 4; i++) begin
      v = m_ctrl[i];
      er[i] = evx(v[18:14], ev, ce);
      ew[i] = evx(v[23:19], ev, ce);
      ef[i] = er[i] & v[26] & v[2];
      if (ce[i]) m_stat[i] = 1'b1;
      if (dn[i] && v[3:2] == 2'h1) m_ctrl[i][3:2] = 2'h0;
    end
    chk_pin("sync events", {20'h0, er, ew, ef}, {20'h0, ar, aw, af});
  endtask : pulse

  // Interrupt line one cycle after the status settles
  task automatic chk_irq();
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    chk_pin("irq", {31'h0, |(m_stat & m_mask)}, {31'h0, irq});
    @(posedge clk_in);
  endtask : chk_irq

  // Hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #200000;
    err_total++;
    close_out();
  end

  // Main sequence
  initial begin
    int          k, n;
    logic [31:0] d;
    logic [13:0] e;
    m_stat = 4'h0;
    m_mask = 4'h0;
    for (k = 0; k < 4; k++) m_ctrl[k] = dpc_pkg::CTRL_RESET;
    void'($urandom(84136));
    repeat (12) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    // Reset image of every place, unmapped ones too
    for (k = 0; k < 8; k++) rd(k); // Reset reads
    for (k = 0; k < 4; k++) fld(k); // Reset fields
    // Random images on random channels, each command code in turn
    for (k = 0; k < 16; k++) begin
      n = $urandom_range(3);
      d = $urandom;
      d[1:0] = k[1:0];
      wr(n, d);
      fld(n); // Field decode
      for (n = 0; n < 4; n++) rd(n); // Per channel
    end
    // Narrow and unmapped writes change nothing
    bus(1'b1, 32'h0, 32'hffff_ffff, 3'h1);
    bus(1'b1, 32'h18, 32'hffff_ffff, 3'h2);
    rd(0); // Narrow write ignored
    rd(6); // Unmapped reads zero
    // Every sync code on both selectors of channel 0, frame sync on
    for (k = 0; k < 32; k++) begin
      wr(0, {8'h04, 5'(k), 5'(k), 14'h0001});
      fld(0); // Reserved flag
      e = 14'($urandom);
      pulse(e, 4'h0); // Selected event
      pulse(~e, 4'h0); // Other lines
    end
    // Completion events, status, mask and channel events
    wr(5, 32'h0);
    wr(0, 32'h0002_8000);
    wr(1, 32'h0000_0001);
    wr(2, 32'h0200_0001);
    wr(3, 32'h0200_0003);
    pulse(14'h0, 4'hf); // Channel 2 event on code Ah
    chk_irq(); // Masked stays low
    for (k = 0; k < 4; k++) rd(k); // Stop or stay autorun
    wr(5, 32'h8);
    chk_irq(); // Unmasked raises the line
    rd(5); // Mask readback
    rd(4); // Status then clears
    chk_irq(); // Line drops once read
    rd(4); // Cleared status
    // Emulation halt pauses only channels that ask for it
    wr(1, 32'h0800_0001);
    wr(2, 32'h0000_0001);
    emu_halt_in <= 1'b1;
    fld(1); // Held channel stops
    fld(2); // Other keeps running
    rd(1); // Shows paused
    rd(2); // Shows running
    emu_halt_in <= 1'b0;
    fld(1); // Resumes after halt
    close_out();
  end
endmodule : dpc_top_tb
`default_nettype wire
